// >>> src/hub_strap_pkg.sv
// Constants for the hub strap sampling and downstream port control block
// Assumes a single 100 MHz system clock and Avalon-MM register access
package hub_strap_pkg;
    ////////////////////////////////////////////////////////////////////////////////
    // Register map, byte addresses
    localparam logic [3:0]  REG_STATUS      = 4'h0;  // Read-only state
    localparam logic [3:0]  REG_CONTROL     = 4'h4;  // Power and LED control
    localparam logic [3:0]  REG_CONFIG      = 4'h8;  // Loaded configuration bits
    localparam logic [3:0]  REG_EVENT       = 4'hC;  // Sticky over-current, write one clears
    ////////////////////////////////////////////////////////////////////////////////
    // Status fields
    localparam int          ST_METHOD_LSB   = 0;     // Two bits of latched method
    localparam int          ST_POLARITY     = 2;     // Latched polarity
    localparam int          ST_FIXED_LSB    = 3;     // Two bits of fixed-port strap
    localparam int          ST_OVERCURRENT  = 5;     // Live over-current level
    localparam int          ST_IN_RESET     = 6;     // Hardware reset pin held low
    localparam int          ST_SMB_ADDR_LSB = 8;     // Seven-bit slave address
    // Control fields
    localparam int          CT_POWER_ON     = 0;     // Request downstream power
    localparam int          CT_LED_ENABLE   = 1;     // LED support enabled by config
    localparam int          CT_LED_ON_LSB   = 2;     // Two LED lit requests
    // Reset values
    localparam logic [31:0] CONTROL_RESET   = 32'h0000_0000;
    localparam logic [31:0] CONFIG_RESET    = 32'h0000_0000;
    localparam logic [31:0] CONFIG_CLEARED  = 32'h0000_0000;
    localparam logic [6:0]  SMBUS_ADDRESS   = 7'h2C;  // 0101100
    localparam int          SYNC_STAGES     = 3;
    ////////////////////////////////////////////////////////////////////////////////
    // Configuration method, select pair hi:lo
    typedef enum logic [1:0]
    {
        METHOD_RESERVED = 2'b00,
        METHOD_SMBUS    = 2'b01,
        METHOD_DEFAULT  = 2'b10,
        METHOD_EEPROM   = 2'b11
    } method_t;
    // Fixed-port strap codes
    localparam logic [1:0]  FIXED_NONE      = 2'b00;
    localparam logic [1:0]  FIXED_PORT1     = 2'b01;
    localparam logic [1:0]  FIXED_BOTH_LED2 = 2'b10;
    localparam logic [1:0]  FIXED_BOTH_LOW  = 2'b11;
endpackage

// >>> src/pin_sync_if.sv
// Interface carrying raw pin levels into the synchroniser and clean levels out
// Assumes both ends run on clk_sys
`timescale 1ns/100ps
`default_nettype none
interface pin_sync_if #(parameter int W = 1);
    logic [W-1:0] raw;    // Pin level from outside
    logic [W-1:0] clean;  // Filtered level in clk_sys domain
    modport sync (input raw, output clean);
    modport user (output raw, input clean);
endinterface
`default_nettype wire

// >>> src/pin_sync.sv
// Three-stage pin synchroniser, a change counts once stages two and three agree
// Assumes a pin input asynchronous to clk_sys
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
    parameter int W = 1
) (
    input  wire logic   clk_sys,
    input  wire logic   rst,
    input  wire logic   clkEn,
    pin_sync_if.sync    pins
);
    ////////////////////////////////////////////////////////////////////////////////
    logic [W-1:0] stage1_ff;  // Metastable stage, read only by stage2
    logic [W-1:0] stage2_ff;  // Second stage
    logic [W-1:0] stage3_ff;  // Third stage
    logic [W-1:0] clean_ff;   // Agreed level

    // Refuse an empty pin group at elaboration
    if (W < 1)
    begin : g_width_check
        $error("pin_sync width must be at least one");
    end

    // Shift chain
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            stage1_ff <= '0;
            stage2_ff <= '0;
            stage3_ff <= '0;
        end
        else if (clkEn)
        begin
            stage1_ff <= pins.raw;
            stage2_ff <= stage1_ff;
            stage3_ff <= stage2_ff;
        end
    end

    // Accept only bits where the last two stages agree
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            clean_ff <= '0;
        else if (clkEn)
            clean_ff <= (stage2_ff & stage3_ff) | (clean_ff & (stage2_ff | stage3_ff));
    end

    assign pins.clean = clean_ff;
endmodule
`default_nettype wire

// >>> src/hub_strap_port_power_ctrl.sv
// Strap sampling at hardware reset release and downstream port power/LED drive
// Assumes pins arrive asynchronously; registers reached over Avalon-MM
//
// The implementer's own choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none
module hub_strap_port_power_ctrl (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        clkEn,
    // Avalon-MM slave
    input  wire logic [3:0]  avsAddress,
    input  wire logic        avsRead,
    input  wire logic        avsWrite,
    input  wire logic [3:0]  avsByteenable,
    input  wire logic [31:0] avsWritedata,
    output logic [31:0]      avsReaddata,
    output logic             avsWaitrequest,
    // Device pins
    input  wire logic        hwResetLow,
    input  wire logic        port_power_polarity_strap,
    input  wire logic        config_method_select_lo,
    input  wire logic        config_method_select_hi,
    input  wire logic        overcurrent_sense_low,
    input  wire logic [1:0]  portGreenLedIn,
    output logic [1:0]       port_green_led,
    output logic [1:0]       portGreenLedOeLow,
    output logic             port_power_enable,
    // Status to the hub core
    input  wire logic        eepromAbsent,
    output logic [1:0]       configMethod,
    output logic             smbusSlaveMode,
    output logic [1:0]       fixedPorts,
    output logic             portOvercurrent
);
    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    pin_sync_if #(.W(7)) pinBus ();  // All pins filtered together
    assign pinBus.raw = {portGreenLedIn, overcurrent_sense_low, config_method_select_hi,
                         config_method_select_lo, port_power_polarity_strap, hwResetLow};

    pin_sync #(.W(7)) u_pin_sync (
        .clk_sys (clk_sys),
        .rst     (rst),
        .clkEn   (clkEn),
        .pins    (pinBus)
    );

    logic       resetPinHigh;  // Filtered hardware reset level
    logic       polarityPin;   // Filtered polarity strap
    logic [1:0] methodPins;    // Filtered select pair hi:lo
    logic       ocsLowPin;     // Filtered over-current sense
    logic [1:0] fixedPins;     // Filtered LED/strap pins
    assign resetPinHigh = pinBus.clean[0];
    assign polarityPin  = pinBus.clean[1];
    assign methodPins   = pinBus.clean[3:2];
    assign ocsLowPin    = pinBus.clean[4];
    assign fixedPins    = pinBus.clean[6:5];

    ////////////////////////////////////////////////////////////////////////////////
    // Hardware reset edge detection
    logic resetPinPrev_ff;  // Previous filtered reset level
    logic strapTake;        // One-cycle rise of the reset pin
    assign strapTake = resetPinHigh & ~resetPinPrev_ff;

    // Track reset pin level
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            resetPinPrev_ff <= 1'b0;
        else if (clkEn)
            resetPinPrev_ff <= resetPinHigh;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Strap latches, loaded only at the reset rise
    hub_strap_pkg::method_t method_ff;       // Latched configuration method
    logic                   polarity_ff;     // Latched power polarity
    logic [1:0]             fixedStrap_ff;   // Latched fixed-port strap

    // Capture straps
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            method_ff     <= hub_strap_pkg::METHOD_RESERVED;
            polarity_ff   <= 1'b0;
            fixedStrap_ff <= hub_strap_pkg::FIXED_NONE;
        end
        else if (clkEn && strapTake)
        begin
            method_ff     <= hub_strap_pkg::method_t'(methodPins);
            polarity_ff   <= polarityPin;
            fixedStrap_ff <= fixedPins;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Fixed-port and LED polarity decode
    logic [1:0] fixedDecode;   // Ports holding attached devices, bit0 port 1
    logic [1:0] ledLowDecode;  // LED active-low per port
    always_comb
    begin
        fixedDecode  = 2'b00;
        ledLowDecode = 2'b00;
        case (fixedStrap_ff)
            hub_strap_pkg::FIXED_NONE:
            begin
                fixedDecode  = 2'b00;
                ledLowDecode = 2'b00;
            end
            hub_strap_pkg::FIXED_PORT1:
            begin
                fixedDecode  = 2'b01;
                ledLowDecode = 2'b01;
            end
            hub_strap_pkg::FIXED_BOTH_LED2:
            begin
                fixedDecode  = 2'b11;
                ledLowDecode = 2'b10;
            end
            default:
            begin
                fixedDecode  = 2'b11;
                ledLowDecode = 2'b11;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register file
    logic [31:0] control_ff;   // Software control
    logic [31:0] config_ff;    // Loaded configuration bits
    logic        ocEvent_ff;   // Sticky over-current
    logic        busAccept;    // Request completes this edge
    logic        isDefault;    // Default method latched
    logic        zeroConfig;   // EEPROM selected but none answers
    logic [31:0] byteMask;     // Write lane mask
    logic        ocLevel;      // Over-current present
    assign busAccept  = (avsRead | avsWrite) & ~avsWaitrequest;
    assign isDefault  = (method_ff == hub_strap_pkg::METHOD_DEFAULT);
    assign zeroConfig = (method_ff == hub_strap_pkg::METHOD_EEPROM) & eepromAbsent;
    assign byteMask   = {{8{avsByteenable[3]}}, {8{avsByteenable[2]}},
                         {8{avsByteenable[1]}}, {8{avsByteenable[0]}}};
    assign ocLevel    = ~ocsLowPin;

    // Control register
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            control_ff <= hub_strap_pkg::CONTROL_RESET;
        else if (clkEn && busAccept && avsWrite && avsAddress == hub_strap_pkg::REG_CONTROL)
            control_ff <= (control_ff & ~byteMask) | (avsWritedata & byteMask);
    end

    // Configuration register, forced to zero when the EEPROM method is latched and no EEPROM answers
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            config_ff <= hub_strap_pkg::CONFIG_RESET;
        else if (clkEn)
        begin
            if (zeroConfig)
                config_ff <= hub_strap_pkg::CONFIG_CLEARED;
            else if (busAccept && avsWrite && avsAddress == hub_strap_pkg::REG_CONFIG)
                config_ff <= (config_ff & ~byteMask) | (avsWritedata & byteMask);
        end
    end

    // Sticky over-current, a new event beats the clear
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            ocEvent_ff <= 1'b0;
        else if (clkEn)
        begin
            if (ocLevel)
                ocEvent_ff <= 1'b1;
            else if (busAccept && avsWrite && avsAddress == hub_strap_pkg::REG_EVENT
                     && avsByteenable[0] && avsWritedata[0])
                ocEvent_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Bus handshake, one wait cycle then answer
    logic [31:0] nxt_readdata;  // Read mux
    always_comb
    begin
        nxt_readdata = 32'h0000_0000;
        case (avsAddress)
            hub_strap_pkg::REG_STATUS:
            begin
                nxt_readdata[hub_strap_pkg::ST_METHOD_LSB +: 2]   = method_ff;
                nxt_readdata[hub_strap_pkg::ST_POLARITY]          = polarity_ff;
                nxt_readdata[hub_strap_pkg::ST_FIXED_LSB +: 2]    = fixedStrap_ff;
                nxt_readdata[hub_strap_pkg::ST_OVERCURRENT]       = ocLevel;
                nxt_readdata[hub_strap_pkg::ST_IN_RESET]          = ~resetPinHigh;
                nxt_readdata[hub_strap_pkg::ST_SMB_ADDR_LSB +: 7] = hub_strap_pkg::SMBUS_ADDRESS;
            end
            hub_strap_pkg::REG_CONTROL: nxt_readdata = control_ff;
            hub_strap_pkg::REG_CONFIG:  nxt_readdata = config_ff;
            hub_strap_pkg::REG_EVENT:   nxt_readdata[0] = ocEvent_ff;
            default:                    nxt_readdata = 32'h0000_0000;  // Unmapped
        endcase
    end

    // Waitrequest and read data
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            avsWaitrequest <= 1'b1;
            avsReaddata    <= 32'h0000_0000;
        end
        else if (clkEn)
        begin
            if ((avsRead | avsWrite) && avsWaitrequest)
            begin
                avsWaitrequest <= 1'b0;
                avsReaddata    <= nxt_readdata;
            end
            else
                avsWaitrequest <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Port power drive
    logic powerWanted;  // Power requested and hardware reset released
    assign powerWanted = resetPinHigh & control_ff[hub_strap_pkg::CT_POWER_ON];

    // Off level follows live strap during reset, latched value after
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            port_power_enable <= 1'b0;
        else if (clkEn)
        begin
            if (!resetPinHigh)
                port_power_enable <= ~polarityPin;
            else
                port_power_enable <= powerWanted ~^ polarity_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Green LED drive; pins released during reset so straps can be read
    logic       ledDrive;     // LEDs driven in this method
    logic [1:0] ledLow;       // Active-low per port
    logic [1:0] ledOn;        // Lit requests
    assign ledDrive = resetPinHigh & (isDefault | control_ff[hub_strap_pkg::CT_LED_ENABLE]);
    assign ledLow   = isDefault ? ledLowDecode : 2'b11;
    assign ledOn    = control_ff[hub_strap_pkg::CT_LED_ON_LSB +: 2];

    // LED outputs and enables
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            port_green_led    <= 2'b00;
            portGreenLedOeLow <= 2'b11;
        end
        else if (clkEn)
        begin
            port_green_led    <= ledOn ^ ledLow;
            portGreenLedOeLow <= {2{~ledDrive}};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Status outputs to the hub core
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            configMethod    <= hub_strap_pkg::METHOD_RESERVED;
            smbusSlaveMode  <= 1'b0;
            fixedPorts      <= 2'b00;
            portOvercurrent <= 1'b0;
        end
        else if (clkEn)
        begin
            configMethod    <= method_ff;
            smbusSlaveMode  <= (method_ff == hub_strap_pkg::METHOD_SMBUS);
            fixedPorts      <= isDefault ? fixedDecode : 2'b00;
            portOvercurrent <= ocLevel;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_resetRise;
        resetPinHigh && !$past(resetPinHigh);
    endsequence
    sequence s_held;
        clkEn && !rst;
    endsequence

    a_strap_polarity_take: assert property (@(posedge clk_sys) disable iff (rst)
        s_resetRise ##0 clkEn |=> polarity_ff == $past(polarityPin))
        else $error("polarity not latched at reset rise");
    a_strap_method_take: assert property (@(posedge clk_sys) disable iff (rst)
        s_resetRise ##0 clkEn |=> method_ff == $past(methodPins))
        else $error("method not latched at reset rise");
    a_strap_hold_steady: assert property (@(posedge clk_sys) disable iff (rst)
        !strapTake |=> $stable(method_ff) && $stable(polarity_ff) && $stable(fixedStrap_ff))
        else $error("strap latch changed without reset rise");
    a_power_off_reset: assert property (@(posedge clk_sys) disable iff (rst)
        s_held ##0 !resetPinHigh |=> port_power_enable == !$past(polarityPin))
        else $error("port power not off during hardware reset");
    a_power_level_pol: assert property (@(posedge clk_sys) disable iff (rst)
        s_held ##0 resetPinHigh |=>
        port_power_enable == ($past(powerWanted) == $past(polarity_ff)))
        else $error("port power level wrong for polarity");
    a_led_low_enabled: assert property (@(posedge clk_sys) disable iff (rst)
        s_held ##0 !isDefault && ledDrive |=> port_green_led == ~$past(ledOn)
        && portGreenLedOeLow == 2'b00)
        else $error("LED not active low when enabled");
    a_led_fixed_decode: assert property (@(posedge clk_sys) disable iff (rst)
        s_held ##0 isDefault && fixedStrap_ff == hub_strap_pkg::FIXED_BOTH_LED2
        |=> port_green_led == ($past(ledOn) ^ 2'b10) && fixedPorts == 2'b11)
        else $error("fixed strap decode wrong");
    a_smbus_mode_out: assert property (@(posedge clk_sys) disable iff (rst)
        s_held |=> smbusSlaveMode == ($past(method_ff) == hub_strap_pkg::METHOD_SMBUS))
        else $error("SMBus mode output wrong");
    a_config_zeroed: assert property (@(posedge clk_sys) disable iff (rst)
        s_held ##0 zeroConfig |=> config_ff == 32'h0000_0000)
        else $error("configuration not zeroed without EEPROM");
    a_overcurrent_sticky: assert property (@(posedge clk_sys) disable iff (rst)
        s_held ##0 ocLevel |=> ocEvent_ff ##1 (ocEvent_ff || !ocLevel && $past(busAccept)))
        else $error("over-current event lost");
    a_bus_one_wait: assert property (@(posedge clk_sys) disable iff (rst)
        s_held ##0 (avsRead || avsWrite) && avsWaitrequest |=> !avsWaitrequest)
        else $error("bus answer late");
endmodule
`default_nettype wire

// >>> bench/hub_pin_partner.sv
// Behavioural model of the straps, LED pins and external power switch
// Assumes the bench sets strap levels and commands over-current faults
`timescale 1ns/100ps
`default_nettype none
module hub_pin_partner (
    input  wire logic       polSet,
    input  wire logic [1:0] selSet,
    input  wire logic [1:0] fixSet,
    input  wire logic       ocFault,
    input  wire logic [1:0] ledOut,
    input  wire logic [1:0] ledOeLow,
    output logic            polPin,
    output logic            selLo,
    output logic            selHi,
    output logic            ocLow,
    output logic [1:0]      ledPin
);
    ////////////////////////////////////////////////////////////////////////////////
    // Strap resistors on the select and polarity pins
    assign polPin         = polSet;
    assign {selHi, selLo} = selSet;
    // Switch pulls the sense line low on a fault, pull-up otherwise
    assign ocLow          = ~ocFault;
    // LED pin shows the driver when enabled, else the strap resistor
    assign ledPin[0]      = ledOeLow[0] ? fixSet[0] : ledOut[0];
    assign ledPin[1]      = ledOeLow[1] ? fixSet[1] : ledOut[1];
endmodule
`default_nettype wire

// >>> bench/hub_strap_port_power_ctrl_test.sv
// Self-checking bench: strap latching, power and LED drive, bus access
// Assumes the pin partner model and a 100 MHz clock
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; \
    $display("[ERR] %0t got %h want %h", $time, a, b); end end
module hub_strap_port_power_ctrl_test;
    logic        clk_sys, rst, clkEn, avsRead, avsWrite, avsWaitrequest;
    logic [3:0]  avsAddress, avsByteenable;
    logic [31:0] avsWritedata, avsReaddata, d;
    logic        hwResetLow, polPin, selLo, selHi, ocLow, power, eepromAbsent;
    logic        smbusSlaveMode, portOvercurrent, polSet, ocFault, pol, drv;
    logic [1:0]  ledIn, ledOut, ledOeLow, configMethod, fixedPorts;
    logic [1:0]  selSet, fixSet, sel, fix, actLow;
    int          error_cnt, checked, cycles, i;
    ////////////////////////////////////////////////////////////////////////////////
    // Device and far-side model
    hub_strap_port_power_ctrl uut (.clk_sys(clk_sys), .rst(rst), .clkEn(clkEn),
        .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
        .avsByteenable(avsByteenable), .avsWritedata(avsWritedata),
        .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest),
        .hwResetLow(hwResetLow), .port_power_polarity_strap(polPin),
        .config_method_select_lo(selLo), .config_method_select_hi(selHi),
        .overcurrent_sense_low(ocLow), .portGreenLedIn(ledIn), .port_green_led(ledOut),
        .portGreenLedOeLow(ledOeLow), .port_power_enable(power),
        .eepromAbsent(eepromAbsent), .configMethod(configMethod),
        .smbusSlaveMode(smbusSlaveMode), .fixedPorts(fixedPorts),
        .portOvercurrent(portOvercurrent));
    hub_pin_partner far (.polSet(polSet), .selSet(selSet), .fixSet(fixSet),
        .ocFault(ocFault), .ledOut(ledOut), .ledOeLow(ledOeLow), .polPin(polPin),
        .selLo(selLo), .selHi(selHi), .ocLow(ocLow), .ledPin(ledIn));
    ////////////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic summarize;
        if (error_cnt == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Bus read: hold until waitrequest low, take data at that edge
    task automatic avsRd(input logic [3:0] a, output logic [31:0] q);
        avsAddress <= a;
        avsRead    <= 1'b1;
        do @(posedge clk_sys); while (avsWaitrequest !== 1'b0);
        q = avsReaddata;
        avsRead <= 1'b0;
        @(posedge clk_sys);
    endtask
    // Bus write, all lanes
    task automatic avsWr(input logic [3:0] a, input logic [31:0] v);
        avsAddress    <= a;
        avsWritedata  <= v;
        avsByteenable <= 4'hF;
        avsWrite      <= 1'b1;
        do @(posedge clk_sys); while (avsWaitrequest !== 1'b0);
        avsWrite <= 1'b0;
        @(posedge clk_sys);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Clock and hang guard
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            error_cnt++;
            summarize();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence: every method, fixed code and polarity
    initial
    begin
        rst = 1'b1; clkEn = 1'b1; avsRead = 1'b0; avsWrite = 1'b0;
        avsAddress = 4'h0; avsByteenable = 4'h0; avsWritedata = 32'h0;
        hwResetLow = 1'b0; polSet = 1'b0; selSet = 2'b10; fixSet = 2'b00;
        ocFault = 1'b0; eepromAbsent = 1'b0;
        error_cnt = 0; checked = 0; cycles = 0;
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        for (i = 0; i < 16; i++)
        begin
            sel = i[3:2]; fix = i[1:0]; pol = i[0] ^ i[2];
            selSet <= sel; fixSet <= fix; polSet <= pol; eepromAbsent <= i[1];
            hwResetLow <= 1'b0;
            repeat (8) @(posedge clk_sys);
            `CHK(power, ~pol)
            hwResetLow <= 1'b1;
            repeat (8) @(posedge clk_sys);
            // Straps move after the latch and must be ignored
            selSet <= ~sel; fixSet <= ~fix; polSet <= ~pol;
            avsWr(hub_strap_pkg::REG_CONTROL, {28'h0, 2'b01, sel == 2'b01, 1'b1});
            repeat (3) @(posedge clk_sys);
            `CHK(configMethod, sel)
            `CHK(configMethod, sel)
            `CHK(smbusSlaveMode, sel == 2'b01)
            `CHK(fixedPorts, (sel == 2'b10) ? {fix[1], |fix} : 2'b00)
            `CHK(power, pol)
            `CHK(power, pol)
            drv = (sel == 2'b10) || (sel == 2'b01);
            actLow = (sel == 2'b10) ? fix : 2'b11;
            `CHK(ledOeLow, drv ? 2'b00 : 2'b11)
            if (drv) `CHK(ledOut, 2'b01 ^ actLow)
            avsRd(hub_strap_pkg::REG_STATUS, d);
            `CHK(d[14:8], hub_strap_pkg::SMBUS_ADDRESS)
            `CHK(d[1:0], sel)
            avsWr(hub_strap_pkg::REG_CONFIG, 32'hA5C3_0F96);
            avsRd(hub_strap_pkg::REG_CONFIG, d);
            `CHK(d, (sel == 2'b11 && eepromAbsent) ? 32'h0 : 32'hA5C3_0F96)
            avsWr(hub_strap_pkg::REG_CONTROL, 32'h0);
            repeat (3) @(posedge clk_sys);
            `CHK(power, ~pol)
        end
        // Over-current level, sticky event and its clear
        ocFault <= 1'b1;
        repeat (8) @(posedge clk_sys);
        `CHK(portOvercurrent, 1'b1)
        ocFault <= 1'b0;
        repeat (8) @(posedge clk_sys);
        `CHK(portOvercurrent, 1'b0)
        avsRd(hub_strap_pkg::REG_EVENT, d);
        `CHK(d[0], 1'b1)
        avsWr(hub_strap_pkg::REG_EVENT, 32'h1);
        avsRd(hub_strap_pkg::REG_EVENT, d);
        `CHK(d[0], 1'b0)
        // Clock enable low freezes the filter and the outputs
        clkEn <= 1'b0;
        ocFault <= 1'b1;
        repeat (8) @(posedge clk_sys);
        `CHK(portOvercurrent, 1'b0)
        clkEn <= 1'b1;
        repeat (8) @(posedge clk_sys);
        `CHK(portOvercurrent, 1'b1)
        ocFault <= 1'b0;
        repeat (8) @(posedge clk_sys);
        // Unmapped read and read-only status
        avsRd(4'h2, d);
        `CHK(d, 32'h0)
        avsWr(hub_strap_pkg::REG_STATUS, 32'hFFFF_FFFF);
        avsRd(hub_strap_pkg::REG_STATUS, d);
        `CHK(d[1:0], 2'b11)
        summarize();
    end
endmodule
`undef CHK
`default_nettype wire
